// file: src/panel_pkg.sv
// Shared constants, register map and carrier types of the panel display block
package panel_pkg;

	localparam int CLK_PERIOD_NS = 8;
	localparam int TICK_PERIOD_NS = 1000000;
	localparam int TICK_CYCLES_DEFAULT = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SHIFT_HOLD_MS = 2000;
	localparam logic [11:0] SHIFT_HOLD_TICKS = 12'(SHIFT_HOLD_MS * 1000000 / TICK_PERIOD_NS);

	localparam int DI_COUNT = 9;
	localparam int DO_COUNT = 6;
	localparam int FAULT_ENTRIES = 5;

	localparam logic [15:0] JOG_SPEED_RESET = 16'h0014;
	localparam logic signed [15:0] JOG_MIN_DEFAULT = -16'sh1388;
	localparam logic signed [15:0] JOG_MAX_DEFAULT = 16'sh1388;
	localparam logic [15:0] MODE_FORCED = 16'h0196;
	localparam logic [15:0] MODE_NORMAL = 16'h0190;

	localparam logic [4:0] ADDR_CONTROL = 5'h00;
	localparam logic [4:0] ADDR_OUTPUT_MODE = 5'h04;
	localparam logic [4:0] ADDR_FORCED_PATTERN = 5'h08;
	localparam logic [4:0] ADDR_JOG_SPEED = 5'h0C;
	localparam logic [4:0] ADDR_STATUS = 5'h10;
	localparam logic [4:0] ADDR_DISPLAY = 5'h14;
	localparam logic [4:0] ADDR_IO = 5'h18;

	localparam int CTRL_PAGE_LSB = 0;
	localparam int CTRL_HEX_BIT = 2;
	localparam int CTRL_HIGH_BIT = 3;
	localparam int CTRL_IDX_LSB = 4;
	localparam int IO_DO_LSB = 16;
	localparam logic [2:0] JOG_PARAM_INDEX = 3'h5;
	localparam logic [2:0] FORCED_PARAM_INDEX = 3'h6;

	localparam logic [4:0] GLYPH_BLANK = 5'h10;
	localparam logic [4:0] GLYPH_HIGH = 5'h11;
	localparam logic [4:0] GLYPH_LOW = 5'h12;

	typedef enum logic [1:0] {page_monitor, page_param, page_di, page_do} page_t;

	typedef struct packed {
		logic set;
		logic up;
		logic down;
		logic shift;
		logic mode;
	} keys_t;

	typedef struct packed {
		logic [4:0][4:0] code;
		logic [4:0]      dp;
	} display_t;

	typedef struct packed {
		logic [31:0] value;
		logic        hex;
		logic        wide;
		logic        high;
		logic        neg;
	} fmt_t;

endpackage

// file: src/bin_to_bcd.sv
// Sequential shift-and-add binary to decimal digit converter
`timescale 1ns/1ps
module bin_to_bcd #(
	parameter int WIDTH = 32,
	parameter int DIGITS = 10
) (
	input  wire logic                  clk,
	input  wire logic                  reset,
	input  wire logic                  start,
	input  wire logic [WIDTH-1:0]      bin,
	output logic      [DIGITS*4-1:0]   bcd,
	output logic                       done
);

	localparam int CW = $clog2(WIDTH);

	logic [WIDTH-1:0]    shreg;
	logic [DIGITS*4-1:0] acc;
	logic [DIGITS*4-1:0] adj;
	logic [CW-1:0]       cnt;
	logic                busy;

	// Digits of five or more get three added before each shift
	always_comb
	begin
		adj = acc;
		for (int i = 0; i < DIGITS; i++)
		begin
			if (acc[i*4 +: 4] >= 4'h5)
				adj[i*4 +: 4] = acc[i*4 +: 4] + 4'h3;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			shreg <= '0;
			acc <= '0;
			cnt <= '0;
			busy <= 1'b0;
			done <= 1'b0;
			bcd <= '0;
		end
		else
		begin
			done <= 1'b0;
			if (start && !busy)
			begin
				shreg <= bin;
				acc <= '0;
				cnt <= '0;
				busy <= 1'b1;
			end
			else if (busy)
			begin
				acc <= {adj[DIGITS*4-2:0], shreg[WIDTH-1]};
				shreg <= {shreg[WIDTH-2:0], 1'b0};
				cnt <= cnt + 1'b1;
				if (cnt == CW'(WIDTH - 1))
				begin
					busy <= 1'b0;
					done <= 1'b1;
					bcd <= {adj[DIGITS*4-2:0], shreg[WIDTH-1]};
				end
			end
		end
	end

endmodule

// file: src/panel_display_and_diagnosis.sv
// Front-panel display formatting, jog, forced outputs and I/O diagnosis
//
// The register offsets and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps

module panel_display_and_diagnosis #(
	parameter int                TICK_CYCLES = panel_pkg::TICK_CYCLES_DEFAULT,
	parameter logic signed [15:0] JOG_MIN = panel_pkg::JOG_MIN_DEFAULT,
	parameter logic signed [15:0] JOG_MAX = panel_pkg::JOG_MAX_DEFAULT
) (
	input  wire logic                                      clk,
	input  wire logic                                      reset,
	input  wire logic [4:0]                                avs_address,
	input  wire logic                                      avs_read,
	input  wire logic                                      avs_write,
	input  wire logic [31:0]                               avs_writedata,
	input  wire logic [3:0]                                avs_byteenable,
	output logic      [31:0]                               avs_readdata,
	output logic                                           avs_waitrequest,
	input  wire panel_pkg::keys_t                          keys,
	input  wire logic [31:0]                               monitor_value,
	input  wire logic                                      monitor_wide,
	input  wire logic                                      servo_enabled,
	input  wire logic [panel_pkg::FAULT_ENTRIES-1:0][15:0] fault_records,
	input  wire logic [panel_pkg::DI_COUNT-1:0]            digital_inputs,
	input  wire logic [panel_pkg::DO_COUNT-1:0]            drive_outputs,
	output logic      [panel_pkg::DO_COUNT-1:0]            digital_outputs,
	output panel_pkg::display_t                            display,
	output logic                                           jog_forward,
	output logic                                           jog_reverse,
	output logic      [15:0]                               jog_speed
);
	import panel_pkg::*;

	typedef enum logic [2:0] {st_monitor, st_param, st_fault, st_jog_speed, st_jog_run, st_di_diag,
		st_do_diag} state_t;

	state_t                 state;
	keys_t                  key_meta;
	keys_t                  key_sync;
	keys_t                  key_prev;
	keys_t                  key_press;
	logic [DI_COUNT-1:0]    di_meta;
	logic [DI_COUNT-1:0]    di_sync;
	logic [31:0]            tick_cnt;
	logic                   tick;
	logic [11:0]            hold_cnt;
	logic                   hold_fire;
	logic [31:0]            control;
	logic [15:0]            output_mode;
	logic                   forced_mode;
	logic [DO_COUNT-1:0]    pattern;
	logic                   accept;
	logic                   commit_wr;
	logic [31:0]            rd_word;
	logic [31:0]            wr_merged;
	logic [31:0]            wr_base;
	logic                   conv_start;
	logic                   conv_done;
	logic [39:0]            bcd;
	fmt_t                   next_src;
	fmt_t                   cur;
	logic [31:0]            mag;
	logic [2:0]             ctrl_idx;
	logic signed [15:0]     jog_s;
	logic signed [15:0]     jog_neg;

	assign ctrl_idx = control[CTRL_IDX_LSB +: 3];
	assign jog_s = signed'(jog_speed);
	assign jog_neg = -jog_s;
	assign key_press = key_sync & ~key_prev;

	// Keys and inputs are pin level and asynchronous to clk
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			key_meta <= '0;
			key_sync <= '0;
			key_prev <= '0;
			di_meta <= '0;
			di_sync <= '0;
		end
		else
		begin
			key_meta <= keys;
			key_sync <= key_meta;
			key_prev <= key_sync;
			di_meta <= digital_inputs;
			di_sync <= di_meta;
		end
	end

	// Millisecond enable for the shift hold timer
	always_ff @(posedge clk)
	begin
		if (reset || tick_cnt == 32'(TICK_CYCLES - 1))
			tick_cnt <= '0;
		else
			tick_cnt <= tick_cnt + 32'h0000_0001;
	end
	assign tick = (tick_cnt == 32'(TICK_CYCLES - 1));

	// Fires once per hold, so keeping the key down does not flip the sign back
	always_ff @(posedge clk)
	begin
		if (reset || !key_sync.shift || state != st_jog_speed)
			hold_cnt <= '0;
		else if (tick && hold_cnt != SHIFT_HOLD_TICKS)
			hold_cnt <= hold_cnt + 12'h001;
	end
	assign hold_fire = tick && key_sync.shift && state == st_jog_speed && hold_cnt == SHIFT_HOLD_TICKS - 12'h001;

	// Avalon slave: waitrequest drops for one cycle, a write lands on that edge
	assign accept = (avs_read || avs_write) && avs_waitrequest;
	assign commit_wr = avs_write && !avs_waitrequest;

	always_comb
	begin
		wr_base = '0;
		unique case (avs_address)
			ADDR_CONTROL:        wr_base = control;
			ADDR_OUTPUT_MODE:    wr_base = {16'h0000, output_mode};
			ADDR_FORCED_PATTERN: wr_base = 32'(pattern);
			ADDR_JOG_SPEED:      wr_base = {16'h0000, jog_speed};
			default:             wr_base = '0;
		endcase
		for (int b = 0; b < 4; b++)
			wr_merged[b*8 +: 8] = avs_byteenable[b] ? avs_writedata[b*8 +: 8] : wr_base[b*8 +: 8];
	end

	always_comb
	begin
		unique case (avs_address)
			ADDR_CONTROL:        rd_word = {25'h0, control[6:0]};
			ADDR_OUTPUT_MODE:    rd_word = {16'h0000, output_mode};
			ADDR_FORCED_PATTERN: rd_word = 32'(pattern);
			ADDR_JOG_SPEED:      rd_word = {16'h0000, jog_speed};
			ADDR_STATUS:         rd_word = {25'h0, servo_enabled, forced_mode, jog_reverse, jog_forward, state};
			ADDR_DISPLAY:        rd_word = 32'(display);
			ADDR_IO:             rd_word = (32'(digital_outputs) << IO_DO_LSB) | 32'(di_sync);
			default:             rd_word = '0;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= '0;
		end
		else
		begin
			avs_waitrequest <= !accept;
			if (accept)
				avs_readdata <= avs_read ? rd_word : 32'h0000_0000;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			control <= '0;
		else if (commit_wr && avs_address == ADDR_CONTROL)
			control <= {25'h0, wr_merged[6:0]};
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			output_mode <= MODE_NORMAL;
			forced_mode <= 1'b0;
		end
		else if (commit_wr && avs_address == ADDR_OUTPUT_MODE)
		begin
			output_mode <= wr_merged[15:0];
			if (wr_merged[15:0] == MODE_FORCED)
				forced_mode <= 1'b1;
			else if (wr_merged[15:0] == MODE_NORMAL)
				forced_mode <= 1'b0;
		end
	end

	// Pattern only lives while forced mode is on
	always_ff @(posedge clk)
	begin
		if (reset || !forced_mode)
			pattern <= '0;
		else if (commit_wr && avs_address == ADDR_FORCED_PATTERN)
			pattern <= wr_merged[DO_COUNT-1:0];
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			digital_outputs <= '0;
		else
			digital_outputs <= forced_mode ? pattern : drive_outputs;
	end

	// Up and down keys step by one, a shift hold negates, and no keypad edit leaves the allowed range
	always_ff @(posedge clk)
	begin
		if (reset)
			jog_speed <= JOG_SPEED_RESET;
		else if (commit_wr && avs_address == ADDR_JOG_SPEED)
			jog_speed <= wr_merged[15:0];
		else if (state == st_jog_speed)
		begin
			if (hold_fire)
			begin
				if (jog_neg >= JOG_MIN && jog_neg <= JOG_MAX && jog_s != -16'sh8000)
					jog_speed <= unsigned'(jog_neg);
			end
			else if (key_press.up && jog_s < JOG_MAX)
				jog_speed <= jog_speed + 16'h0001;
			else if (key_press.down && jog_s > JOG_MIN)
				jog_speed <= jog_speed - 16'h0001;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			state <= st_monitor;
		else if (commit_wr && avs_address == ADDR_CONTROL)
		begin
			unique case (page_t'(wr_merged[CTRL_PAGE_LSB +: 2]))
				page_monitor: state <= st_monitor;
				page_param:   state <= st_param;
				page_di:      state <= st_di_diag;
				page_do:      state <= st_do_diag;
			endcase
		end
		else
		begin
			unique case (state)
				st_param:
				begin
					if (key_press.set && ctrl_idx < 3'(FAULT_ENTRIES))
						state <= st_fault;
					else if (key_press.set && ctrl_idx == JOG_PARAM_INDEX)
						state <= st_jog_speed;
				end
				st_jog_speed:
				begin
					if (key_press.set)
						state <= st_jog_run;
					else if (key_press.mode)
						state <= st_param;
				end
				st_fault, st_jog_run:
				begin
					if (key_press.mode)
						state <= st_param;
				end
				st_monitor, st_di_diag, st_do_diag:
					state <= state;
			endcase
		end
	end

	// Motion stops one edge after servo enable goes away and three edges after the held key is released
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			jog_forward <= 1'b0;
			jog_reverse <= 1'b0;
		end
		else
		begin
			jog_forward <= state == st_jog_run && servo_enabled && key_sync.up && !key_sync.down;
			jog_reverse <= state == st_jog_run && servo_enabled && key_sync.down && !key_sync.up;
		end
	end

	// One formatter serves every page, so monitor and edit screens look alike
	always_comb
	begin
		next_src = '0;
		unique case (state)
			st_monitor:
			begin
				next_src.wide = monitor_wide;
				next_src.hex = monitor_wide && control[CTRL_HEX_BIT];
				next_src.high = monitor_wide && control[CTRL_HIGH_BIT];
				next_src.value = monitor_wide ? monitor_value : {{16{monitor_value[15]}}, monitor_value[15:0]};
			end
			st_param:
			begin
				if (ctrl_idx == FORCED_PARAM_INDEX)
				begin
					next_src.hex = 1'b1;
					next_src.value = 32'(pattern);
				end
				else if (ctrl_idx == JOG_PARAM_INDEX)
					next_src.value = {{16{jog_speed[15]}}, jog_speed};
				else
					next_src.value = 32'(ctrl_idx);
			end
			st_fault:
			begin
				next_src.hex = 1'b1;
				next_src.value = {16'h0000, fault_records[ctrl_idx]};
			end
			st_jog_speed, st_jog_run:
				next_src.value = {{16{jog_speed[15]}}, jog_speed};
			st_di_diag:
			begin
				next_src.hex = 1'b1;
				next_src.value = 32'(di_sync);
			end
			st_do_diag:
			begin
				next_src.hex = 1'b1;
				next_src.value = 32'(digital_outputs);
			end
		endcase
		next_src.neg = !next_src.hex && next_src.value[31];
		mag = next_src.neg ? 32'h0000_0000 - next_src.value : next_src.value;
	end

	// Conversion runs back to back, so the screen refreshes every 34 cycles
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			conv_start <= 1'b1;
			cur <= '0;
		end
		else
		begin
			conv_start <= conv_done;
			if (conv_start)
				cur <= next_src;
		end
	end

	bin_to_bcd #(
		.WIDTH  (32),
		.DIGITS (10)
	) bin_to_bcd_i (
		.clk    (clk),
		.reset  (reset),
		.start  (conv_start),
		.bin    (mag),
		.bcd    (bcd),
		.done   (conv_done)
	);

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			display.code <= {5{GLYPH_BLANK}};
			display.dp <= '0;
		end
		else if (conv_done)
		begin
			display.dp <= '0;
			if (cur.hex)
			begin
				for (int d = 0; d < 4; d++)
					display.code[d] <= {1'b0, cur.high ? cur.value[16+d*4 +: 4] : cur.value[d*4 +: 4]};
				if (!cur.wide)
					display.code[4] <= GLYPH_BLANK;
				else
					display.code[4] <= cur.high ? GLYPH_HIGH : GLYPH_LOW;
			end
			else
			begin
				for (int d = 0; d < 5; d++)
					display.code[d] <= {1'b0, cur.high ? bcd[20+d*4 +: 4] : bcd[d*4 +: 4]};
				display.dp[1] <= cur.wide && cur.high;
				display.dp[4] <= cur.neg;
				display.dp[3] <= cur.neg;
			end
		end
	end

endmodule

// file: sim/panel_checker.sv
// Port assertions for the panel display block
`timescale 1ns/1ps
module panel_checker
	import panel_pkg::*;
(
	input wire logic		clk,
	input wire logic		reset,
	input wire logic		avs_read,
	input wire logic		avs_write,
	input wire logic		avs_waitrequest,
	input wire panel_pkg::keys_t	keys,
	input wire logic		servo_enabled,
	input wire panel_pkg::display_t	display,
	input wire logic		jog_forward,
	input wire logic		jog_reverse
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	wait_pulse_a: assert property
		(!avs_waitrequest |=> avs_waitrequest) else $error("waitrequest low for more than one cycle");
	bus_answer_a: assert property
		((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("access not answered");
	jog_servo_a: assert property
		((jog_forward || jog_reverse) |-> $past(servo_enabled)) else $error("jog without servo enable");
	jog_excl_a: assert property
		(!(jog_forward && jog_reverse)) else $error("jog both directions");
	// Two sync stages plus the output register give three edges of lag
	fwd_stop_a: assert property
		(!keys.up [*4] |-> !jog_forward) else $error("forward jog after key release");
	rev_stop_a: assert property
		(!keys.down [*4] |-> !jog_reverse) else $error("reverse jog after key release");
	neg_pair_a: assert property
		(display.dp[4] == display.dp[3] && !display.dp[2] && !display.dp[0]) else $error("sign points wrong");
	hex_nosign_a: assert property
		(display.code[4] >= GLYPH_BLANK |-> display.dp == 5'h00) else $error("sign shown on hex screen");
	high_dec_a: assert property
		(display.dp[1] |-> display.code[4] < 5'h0A && display.code[0] < 5'h0A) else $error("high screen not decimal");

	cover property (jog_forward);
	cover property (jog_reverse);
	cover property (display.code[4] == GLYPH_HIGH);
	cover property (display.dp[1]);
endmodule

bind panel_display_and_diagnosis panel_checker panel_checker_i (.clk(clk), .reset(reset), .avs_read(avs_read),
	.avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .keys(keys), .servo_enabled(servo_enabled),
	.display(display), .jog_forward(jog_forward), .jog_reverse(jog_reverse));

// file: sim/panel_keypad.sv
// Operator keypad model driving key levels
`timescale 1ns/1ps
module panel_keypad
	import panel_pkg::*;
(
	input wire logic		clk,
	output panel_pkg::keys_t	keys
);
	initial keys = '0;
	task automatic lvl(input int k, input logic v);
		@(posedge clk);
		keys[k] <= v;
	endtask
	// Gap after release so the synchronised edges of two presses never merge
	task automatic tap(input int k, input int n);
		lvl(k, 1'b1);
		repeat (n) @(posedge clk);
		lvl(k, 1'b0);
		repeat (6) @(posedge clk);
	endtask
endmodule

// file: sim/panel_display_and_diagnosis_tb.sv
// Self-checking bench for the panel display block
`timescale 1ns/1ps
module panel_display_and_diagnosis_tb;
	import panel_pkg::*;
	logic				clk = 0;
	logic				reset = 1;
	logic [4:0]			avs_address = 5'h00;
	logic				avs_read = 0;
	logic				avs_write = 0;
	logic [31:0]			avs_writedata = 32'h0;
	logic [3:0]			avs_byteenable = 4'hF;
	logic [31:0]			avs_readdata;
	logic				avs_waitrequest;
	keys_t				keys;
	logic [31:0]			monitor_value = 32'h0;
	logic				monitor_wide = 0;
	logic				servo_enabled = 0;
	logic [FAULT_ENTRIES-1:0][15:0]	fault_records = '0;
	logic [DI_COUNT-1:0]		digital_inputs = '0;
	logic [DO_COUNT-1:0]		drive_outputs = '0;
	logic [DO_COUNT-1:0]		digital_outputs;
	display_t			display;
	logic				jog_forward;
	logic				jog_reverse;
	logic [15:0]			jog_speed;
	logic [3:0]			be = 4'hF;
	logic [31:0]			rd;
	int				error_cnt = 0;
	int				checks_done = 0;
	int				cycles = 0;

	always #4 clk = ~clk;
	panel_keypad panel_keypad_i (.clk(clk), .keys(keys));
	// Short tick keeps the two-second shift hold at 8000 cycles
	panel_display_and_diagnosis #(.TICK_CYCLES(4)) panel_display_and_diagnosis_i (.clk(clk), .reset(reset),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.keys(keys), .monitor_value(monitor_value), .monitor_wide(monitor_wide), .servo_enabled(servo_enabled),
		.fault_records(fault_records), .digital_inputs(digital_inputs), .drive_outputs(drive_outputs),
		.digital_outputs(digital_outputs), .display(display), .jog_forward(jog_forward),
		.jog_reverse(jog_reverse), .jog_speed(jog_speed));

	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e)
		begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_read <= !w;
		avs_write <= w;
		@(posedge clk);
		while (avs_waitrequest)
			@(posedge clk);
		rd = avs_readdata;
		avs_read <= 0;
		avs_write <= 0;
		// A write lands on the completing edge and outputs follow one edge later, so let both settle
		repeat (2) @(posedge clk);
	endtask
	function automatic display_t dv(input logic [4:0] ld, input logic [15:0] n, input logic [4:0] p);
		return {ld, 1'b0, n[15:12], 1'b0, n[11:8], 1'b0, n[7:4], 1'b0, n[3:0], p};
	endfunction
	// Display refresh settles within about 70 cycles of a source change
	task automatic see(input string n, input display_t e);
		repeat (100) @(posedge clk);
		chk(n, display, e);
	endtask
	task automatic state(input logic [2:0] e);
		bus(0, ADDR_STATUS, 32'h0);
		chk("state", rd[2:0], e);
	endtask
	task automatic jk(input int k, input logic srv, input logic [1:0] e);
		@(posedge clk);
		servo_enabled <= srv;
		panel_keypad_i.lvl(k, 1'b1);
		repeat (6) @(posedge clk);
		chk("jog held", {jog_forward, jog_reverse}, e);
		panel_keypad_i.lvl(k, 1'b0);
		repeat (6) @(posedge clk);
		chk("jog released", {jog_forward, jog_reverse}, 2'b00);
	endtask

	task automatic t_reset();
		chk("jog reset", jog_speed, JOG_SPEED_RESET);
		bus(0, ADDR_OUTPUT_MODE, 32'h0);
		chk("mode reset", rd, MODE_NORMAL);
		bus(0, 5'h1C, 32'h0);
		chk("unmapped", rd, 32'h0);
		be = 4'h1;
		bus(1, ADDR_JOG_SPEED, 32'h00001234);
		chk("lane write", jog_speed, 16'h0034);
		be = 4'hF;
		bus(1, ADDR_JOG_SPEED, 32'(JOG_SPEED_RESET));
	endtask
	task automatic t_mon();
		monitor_value <= 32'd1234;
		bus(1, ADDR_CONTROL, 32'h04);
		see("dec16", dv(5'h00, 16'h1234, 5'h00));
		monitor_value <= 32'h0000CFC7;
		see("neg16", dv(5'h01, 16'h2345, 5'h18));
		monitor_wide <= 1;
		monitor_value <= 32'd1234567890;
		bus(1, ADDR_CONTROL, 32'h00);
		see("dec32 low", dv(5'h06, 16'h7890, 5'h00));
		bus(1, ADDR_CONTROL, 32'h08);
		see("dec32 high", dv(5'h01, 16'h2345, 5'h02));
		monitor_value <= 32'h12345678;
		bus(1, ADDR_CONTROL, 32'h0C);
		see("hex32 high", dv(GLYPH_HIGH, 16'h1234, 5'h00));
		bus(1, ADDR_CONTROL, 32'h04);
		see("hex32 low", dv(GLYPH_LOW, 16'h5678, 5'h00));
	endtask
	task automatic t_force();
		drive_outputs <= 6'h2A;
		bus(1, ADDR_FORCED_PATTERN, 32'h5);
		bus(0, ADDR_FORCED_PATTERN, 32'h0);
		chk("pattern idle", rd, 32'h0);
		bus(1, ADDR_OUTPUT_MODE, 32'(MODE_FORCED));
		bus(1, ADDR_FORCED_PATTERN, 32'h5);
		chk("force 5", digital_outputs, 6'h05);
		bus(1, ADDR_FORCED_PATTERN, 32'h2);
		chk("force 2", digital_outputs, 6'h02);
		bus(1, ADDR_CONTROL, 32'h61);
		see("pattern view", dv(GLYPH_BLANK, 16'h0002, 5'h00));
		bus(1, ADDR_OUTPUT_MODE, 32'(MODE_NORMAL));
		bus(1, ADDR_OUTPUT_MODE, 32'(MODE_FORCED));
		bus(0, ADDR_FORCED_PATTERN, 32'h0);
		chk("pattern dropped", rd, 32'h0);
		bus(1, ADDR_OUTPUT_MODE, 32'(MODE_NORMAL));
		chk("normal outs", digital_outputs, 6'h2A);
	endtask
	task automatic t_diag();
		digital_inputs <= 9'h1E1;
		drive_outputs <= 6'h0D;
		bus(1, ADDR_CONTROL, 32'h02);
		see("inputs", dv(GLYPH_BLANK, 16'h01E1, 5'h00));
		bus(0, ADDR_IO, 32'h0);
		chk("io", rd, 32'h000D01E1);
		bus(1, ADDR_CONTROL, 32'h03);
		see("outputs", dv(GLYPH_BLANK, 16'h000D, 5'h00));
	endtask
	task automatic t_fault();
		fault_records <= {16'h4A5C, 16'h3A5C, 16'h2A5C, 16'h1A5C, 16'h0A5C};
		for (int i = 0; i < FAULT_ENTRIES; i++)
		begin
			bus(1, ADDR_CONTROL, 32'h01 | (32'(i) << 4));
			panel_keypad_i.tap(4, 4);
			state(3'h2);
			see("fault", dv(GLYPH_BLANK, 16'h0A5C | (16'(i) << 12), 5'h00));
			panel_keypad_i.tap(0, 4);
		end
	endtask
	task automatic t_jog();
		bus(1, ADDR_CONTROL, 32'h51);
		panel_keypad_i.tap(4, 4);
		state(3'h3);
		see("jog view", dv(5'h00, 16'h0020, 5'h00));
		panel_keypad_i.tap(3, 4);
		panel_keypad_i.tap(3, 4);
		panel_keypad_i.tap(2, 4);
		chk("jog adjust", jog_speed, 16'h0015);
		panel_keypad_i.tap(1, 8100);
		chk("sign swap", jog_speed, 16'hFFEB);
		see("neg edit", dv(5'h00, 16'h0021, 5'h18));
		panel_keypad_i.tap(4, 4);
		state(3'h4);
		jk(3, 1'b0, 2'b00);
		jk(3, 1'b1, 2'b10);
		jk(2, 1'b1, 2'b01);
		jk(2, 1'b0, 2'b00);
		panel_keypad_i.tap(0, 4);
		state(3'h1);
	endtask

	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 40000)
		begin
			error_cnt++;
			results();
		end
	end
	initial
	begin
		repeat (12) @(posedge clk);
		reset <= 0;
		repeat (2) @(posedge clk);
		t_reset();
		t_mon();
		t_force();
		t_diag();
		t_fault();
		t_jog();
		results();
	end
endmodule
